// ### src/pdecs_regs.sv
// device error control/status bank with link capabilities
// assumes config reads/writes arrive as single-cycle strobes with
// a byte offset; event inputs are one-cycle pulses on mclk_in
`timescale 1ns/1ps

// Operation
// R1: fatal enable gates fatal message
// R2: nonfatal enable gates nonfatal message
// R3: correctable enable gates correctable message
// R4: status bits 15:6 read zero
// R5: pending set while non-posted outstanding; tracker count stops at 4, so pending drops while requests beyond 4 remain
// R6: aux power bit mirrors presence
// R7: unsupported request sets sticky bit
// R8: fatal error sets bit regardless enable
// R9: nonfatal error sets sticky bit
// R10: correctable error sets sticky bit
// R11: link capabilities read-only, writes ignored
// R12: unsupported request enable sends nonfatal message
// R13: write one clears; set wins
module pdecs_regs
	import pdecs_pkg::*;
(
	// clock and reset
	input wire logic mclk_in,
	input wire logic srst_in,
	// config access
	input wire logic cfg_wr_in,
	input wire logic cfg_rd_in,
	input wire logic [7:0] cfg_addr_in,
	input wire logic [31:0] cfg_wdata_in,
	output logic [31:0] cfg_rdata_out,
	output logic cfg_rvalid_out,
	// error and transaction events
	input wire logic corr_err_in,
	input wire logic nonfatal_err_in,
	input wire logic fatal_err_in,
	input wire logic unsupp_req_in,
	input wire logic np_issue_in,
	input wire logic np_done_in,
	input wire logic aux_power_present_in,
	// messages upstream
	output logic msg_valid_out,
	output pdecs_msg_t msg_type_out,
	output logic msg_cor_out,
	output logic msg_nonfatal_out,
	output logic msg_fatal_out
);
	default clocking mclk_cb @(posedge mclk_in);
	endclocking
	default disable iff (srst_in);

	logic fatal_report_en_q;
	logic nonfatal_report_en_q;
	logic correctable_report_en_q;
	logic unsupp_req_report_en_q;
	logic unsupp_req_seen_q;
	logic fatal_err_seen_q;
	logic nonfatal_err_seen_q;
	logic correctable_err_seen_q;
	logic aux_power_present_q;
	logic nonposted_outstanding;
	logic wr_ctrl;
	logic wr_stat;
	logic [15:0] stat_word;
	logic [15:0] ctrl_word;
	logic send_fatal;
	logic send_nonfatal;
	logic send_cor;
	logic clr_ur;
	logic clr_fatal;
	logic clr_nf;
	logic clr_cor;

	// sticky bit update: set beats a concurrent one-write
	function automatic logic sticky(input logic cur, input logic set,
		input logic clr);
		sticky = set | (cur & ~clr);
	endfunction

	assign wr_ctrl = cfg_wr_in && (cfg_addr_in == DEV_CTRL_OFF);
	assign wr_stat = cfg_wr_in && (cfg_addr_in == DEV_STAT_OFF);

	// R13: one-write clear strobes
	assign clr_ur = wr_stat & cfg_wdata_in[ST_UR_BIT];
	assign clr_fatal = wr_stat & cfg_wdata_in[ST_FATAL_BIT];
	assign clr_nf = wr_stat & cfg_wdata_in[ST_NONFATAL_BIT];
	assign clr_cor = wr_stat & cfg_wdata_in[ST_CORR_BIT];

	pdecs_np_tracker u_np (
		.mclk_in(mclk_in),
		.srst_in(srst_in),
		.np_issue_in(np_issue_in),
		.np_done_in(np_done_in),
		.outstanding_out(nonposted_outstanding)
	);

	// enable bits, low nibble of device control only
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			{unsupp_req_report_en_q, fatal_report_en_q,
				nonfatal_report_en_q, correctable_report_en_q} <= CTL_RESET;
		end else if (wr_ctrl) begin
			unsupp_req_report_en_q <= cfg_wdata_in[CTL_UR_BIT];
			fatal_report_en_q <= cfg_wdata_in[CTL_FATAL_BIT];
			nonfatal_report_en_q <= cfg_wdata_in[CTL_NONFATAL_BIT];
			correctable_report_en_q <= cfg_wdata_in[CTL_CORR_BIT];
		end
	end

	// sticky error-detected bits; status write data sits in low half
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			{unsupp_req_seen_q, fatal_err_seen_q, nonfatal_err_seen_q,
				correctable_err_seen_q} <= STAT_RESET;
		end else begin
			// R7: unsupported sets
			unsupp_req_seen_q <= sticky(unsupp_req_seen_q, unsupp_req_in,
				clr_ur);
			// R8: fatal always sets
			fatal_err_seen_q <= sticky(fatal_err_seen_q, fatal_err_in,
				clr_fatal);
			// R9: nonfatal sets
			nonfatal_err_seen_q <= sticky(nonfatal_err_seen_q,
				nonfatal_err_in, clr_nf);
			// R10: correctable sets
			// R13: one clears, set wins
			correctable_err_seen_q <= sticky(correctable_err_seen_q,
				corr_err_in, clr_cor);
		end
	end

	// R6: aux presence registered
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			aux_power_present_q <= 1'b0;
		end else begin
			aux_power_present_q <= aux_power_present_in;
		end
	end

	// R4: reserved bits zero
	always_comb begin
		stat_word = STAT_RSVD_ZERO;
		// R5: pending from tracker
		stat_word[ST_NONPOSTED_OUTSTANDING_BIT] = nonposted_outstanding;
		stat_word[ST_AUX_BIT] = aux_power_present_q;
		stat_word[ST_UR_BIT] = unsupp_req_seen_q;
		stat_word[ST_FATAL_BIT] = fatal_err_seen_q;
		stat_word[ST_NONFATAL_BIT] = nonfatal_err_seen_q;
		stat_word[ST_CORR_BIT] = correctable_err_seen_q;
		ctrl_word = 16'h0000;
		ctrl_word[CTL_UR_BIT] = unsupp_req_report_en_q;
		ctrl_word[CTL_FATAL_BIT] = fatal_report_en_q;
		ctrl_word[CTL_NONFATAL_BIT] = nonfatal_report_en_q;
		ctrl_word[CTL_CORR_BIT] = correctable_report_en_q;
	end

	// R11: link caps constant, no write path
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			cfg_rdata_out <= 32'h0000_0000;
			cfg_rvalid_out <= 1'b0;
		end else begin
			cfg_rvalid_out <= cfg_rd_in;
			if (!cfg_rd_in) begin
				cfg_rdata_out <= 32'h0000_0000;
			end else if (cfg_addr_in == DEV_CTRL_OFF) begin
				cfg_rdata_out <= {stat_word, ctrl_word};
			end else if (cfg_addr_in == DEV_STAT_OFF) begin
				cfg_rdata_out <= {16'h0000, stat_word};
			end else if (cfg_addr_in == LINK_CAP_OFF) begin
				cfg_rdata_out <= LINK_CAP_DEFAULT;
			end else begin
				cfg_rdata_out <= 32'h0000_0000;
			end
		end
	end

	// R1: fatal gated by enable
	assign send_fatal = fatal_err_in & fatal_report_en_q;
	// R2: nonfatal gated by enable
	// R12: unsupported request reported nonfatal
	assign send_nonfatal = (nonfatal_err_in & nonfatal_report_en_q) |
		(unsupp_req_in & unsupp_req_report_en_q);
	// R3: correctable gated by enable
	assign send_cor = corr_err_in & correctable_report_en_q;

	// one cycle after event; fatal outranks on the type encoding
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			msg_fatal_out <= 1'b0;
			msg_nonfatal_out <= 1'b0;
			msg_cor_out <= 1'b0;
			msg_valid_out <= 1'b0;
			msg_type_out <= PDECS_MSG_COR;
		end else begin
			msg_fatal_out <= send_fatal;
			msg_nonfatal_out <= send_nonfatal;
			msg_cor_out <= send_cor;
			msg_valid_out <= send_fatal | send_nonfatal | send_cor;
			if (send_fatal) begin
				msg_type_out <= PDECS_MSG_FATAL;
			end else if (send_nonfatal) begin
				msg_type_out <= PDECS_MSG_NONFATAL;
			end else begin
				msg_type_out <= PDECS_MSG_COR;
			end
		end
	end

	// assertions use the default clock and stay off during reset
	sequence ur_event_s;
		unsupp_req_in;
	endsequence

	// seen now, still seen next cycle unless a clear came in between
	sequence ur_held_s;
		unsupp_req_seen_q ##1 (unsupp_req_seen_q || $past(clr_ur));
	endsequence

	sequence fatal_clear_s;
		clr_fatal && !fatal_err_in;
	endsequence

	sequence cor_clash_s;
		corr_err_in && clr_cor;
	endsequence

	fatal_msg_gate_a: assert property ( // R1
		fatal_err_in |=> (msg_fatal_out == $past(fatal_report_en_q)))
		else $error("fatal message not gated by enable");
	fatal_type_a: assert property ( // R1
		(fatal_err_in && fatal_report_en_q) |=>
		(msg_valid_out && msg_type_out == PDECS_MSG_FATAL))
		else $error("fatal message without fatal type");
	nonfatal_msg_a: assert property ( // R2
		(nonfatal_err_in && nonfatal_report_en_q) |=> msg_nonfatal_out)
		else $error("nonfatal message missing");
	nf_type_a: assert property ( // R2
		(nonfatal_err_in && nonfatal_report_en_q &&
		!(fatal_err_in && fatal_report_en_q)) |=>
		(msg_type_out == PDECS_MSG_NONFATAL))
		else $error("nonfatal message with wrong type");
	nonfatal_quiet_a: assert property ( // R2
		(!(nonfatal_err_in && nonfatal_report_en_q) &&
		!(unsupp_req_in && unsupp_req_report_en_q)) |=>
		!msg_nonfatal_out)
		else $error("nonfatal message while not enabled");
	cor_msg_a: assert property ( // R3
		!correctable_report_en_q |=> !msg_cor_out)
		else $error("correctable message while disabled");
	cor_send_a: assert property ( // R3
		(corr_err_in && correctable_report_en_q) |=> msg_cor_out)
		else $error("correctable message missing");
	rsvd_zero_a: assert property ( // R4
		(cfg_rd_in && cfg_addr_in == DEV_STAT_OFF) |=>
		(cfg_rdata_out[15:6] == 10'h000))
		else $error("reserved status bits nonzero");
	rsvd_hi_a: assert property ( // R4
		(cfg_rd_in && cfg_addr_in == DEV_CTRL_OFF) |=>
		(cfg_rdata_out[31:22] == 10'h000))
		else $error("reserved status bits nonzero in upper half");
	nonposted_outstanding_track_a: assert property ( // R5
		(np_issue_in && !np_done_in) |=> nonposted_outstanding)
		else $error("pending not set after issue");
	nonposted_outstanding_clear_a: assert property ( // R5
		(!nonposted_outstanding && !np_issue_in) |=>
		!nonposted_outstanding)
		else $error("pending set with nothing issued");
	nonposted_outstanding_read_a: assert property ( // R5
		(cfg_rd_in && cfg_addr_in == DEV_STAT_OFF) |=>
		(cfg_rdata_out[ST_NONPOSTED_OUTSTANDING_BIT] == $past(nonposted_outstanding)))
		else $error("pending bit read back wrong");
	aux_mirror_a: assert property ( // R6
		!$past(srst_in) |->
		(aux_power_present_q == $past(aux_power_present_in)))
		else $error("aux bit does not follow presence");
	aux_read_a: assert property ( // R6
		(cfg_rd_in && cfg_addr_in == DEV_STAT_OFF) |=>
		(cfg_rdata_out[ST_AUX_BIT] == $past(aux_power_present_q)))
		else $error("aux bit read back wrong");
	ur_sticky_a: assert property ( // R7
		ur_event_s |=> ur_held_s)
		else $error("unsupported bit lost");
	fatal_set_a: assert property ( // R8
		(fatal_err_in && !fatal_report_en_q) |=> fatal_err_seen_q)
		else $error("fatal bit not set when disabled");
	fatal_hold_a: assert property ( // R8
		(fatal_err_seen_q && !clr_fatal) |=> fatal_err_seen_q)
		else $error("fatal bit dropped");
	nf_set_a: assert property ( // R9
		nonfatal_err_in |=> nonfatal_err_seen_q)
		else $error("nonfatal bit not set");
	nf_hold_a: assert property ( // R9
		(nonfatal_err_seen_q && !wr_stat) |=> nonfatal_err_seen_q)
		else $error("nonfatal bit dropped");
	cor_set_a: assert property ( // R10 R13
		cor_clash_s |=> correctable_err_seen_q)
		else $error("correctable set lost to clear");
	cor_hold_a: assert property ( // R10
		(correctable_err_seen_q && !clr_cor) |=>
		correctable_err_seen_q)
		else $error("correctable bit dropped");
	linkcap_ro_a: assert property ( // R11
		(cfg_rd_in && cfg_addr_in == LINK_CAP_OFF) |=>
		(cfg_rdata_out == LINK_CAP_DEFAULT))
		else $error("link capabilities changed");
	linkcap_wr_a: assert property ( // R11
		(cfg_wr_in && cfg_addr_in == LINK_CAP_OFF) |=>
		$stable(ctrl_word))
		else $error("link capabilities write changed control");
	ur_report_a: assert property ( // R12
		(unsupp_req_in && unsupp_req_report_en_q) |=> msg_nonfatal_out)
		else $error("unsupported request not reported");
	w1c_a: assert property ( // R13
		fatal_clear_s |=> !fatal_err_seen_q)
		else $error("write one did not clear");
endmodule

// ### src/pdecs_pkg.sv
// constants for device error control/status and link capabilities
// assumes an 8-bit byte-offset config access port supplied by the core
package pdecs_pkg;
	localparam logic [7:0] DEV_CTRL_OFF = 8'h78;
	localparam logic [7:0] DEV_STAT_OFF = 8'h7A;
	localparam logic [7:0] LINK_CAP_OFF = 8'h7C;
	localparam int CTL_CORR_BIT = 0;
	localparam int CTL_NONFATAL_BIT = 1;
	localparam int CTL_FATAL_BIT = 2;
	localparam int CTL_UR_BIT = 3;
	localparam int ST_CORR_BIT = 0;
	localparam int ST_NONFATAL_BIT = 1;
	localparam int ST_FATAL_BIT = 2;
	localparam int ST_UR_BIT = 3;
	localparam int ST_AUX_BIT = 4;
	localparam int ST_NONPOSTED_OUTSTANDING_BIT = 5;
	localparam logic [3:0] CTL_RESET = 4'h0;
	localparam logic [3:0] STAT_RESET = 4'h0;
	localparam logic [15:0] STAT_RSVD_ZERO = 16'h0000;
	// board-dependent bits of the capability word taken as zero
	localparam logic [31:0] LINK_CAP_DEFAULT = 32'h0004_0C11;
	localparam logic [2:0] NP_CNT_RESET = 3'h0;
	localparam logic [2:0] NP_CNT_MAX = 3'h4;
	typedef enum logic [1:0] {
		PDECS_MSG_COR,
		PDECS_MSG_NONFATAL,
		PDECS_MSG_FATAL
	} pdecs_msg_t;
endpackage

// ### src/pdecs_np_tracker.sv
// counter of non-posted requests still awaiting completion
// assumes issue and completion are single-cycle pulses
`timescale 1ns/1ps
module pdecs_np_tracker
	import pdecs_pkg::*;
(
	// clock and reset
	input wire logic mclk_in,
	input wire logic srst_in,
	// events
	input wire logic np_issue_in,
	input wire logic np_done_in,
	// status
	output logic outstanding_out
);
	logic [2:0] cnt_q;

	// issue and done in one cycle cancel out
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			cnt_q <= NP_CNT_RESET;
		end else if (np_issue_in && !np_done_in && cnt_q != NP_CNT_MAX) begin
			cnt_q <= cnt_q + 3'h1;
		end else if (np_done_in && !np_issue_in && cnt_q != NP_CNT_RESET) begin
			cnt_q <= cnt_q - 3'h1;
		end
	end

	assign outstanding_out = (cnt_q != NP_CNT_RESET);
endmodule

// ### testbench/pdecs_rc_model.sv
// root complex stand-in: tallies error messages by type
// assumes one-cycle message pulses on mclk_in
`timescale 1ns/1ps
module pdecs_rc_model
	import pdecs_pkg::*;
(
	// clock and reset
	input wire logic mclk_in,
	input wire logic srst_in,
	// messages from the bridge
	input wire logic msg_valid_in,
	input wire pdecs_msg_t msg_type_in,
	// tallies
	output logic [7:0] cor_cnt_out,
	output logic [7:0] nf_cnt_out,
	output logic [7:0] fat_cnt_out
);
	// accepts every message at once, never stalls
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			cor_cnt_out <= 8'h00;
			nf_cnt_out <= 8'h00;
			fat_cnt_out <= 8'h00;
		end else if (msg_valid_in) begin
			case (msg_type_in)
			PDECS_MSG_COR: cor_cnt_out <= cor_cnt_out + 8'h01;
			PDECS_MSG_NONFATAL: nf_cnt_out <= nf_cnt_out + 8'h01;
			default: fat_cnt_out <= fat_cnt_out + 8'h01;
			endcase
		end
	end
endmodule

// ### testbench/pdecs_regs_tb_top.sv
// self-checking bench for the error control/status bank
// assumes reads and events are answered one cycle later
`timescale 1ns/1ps
module pdecs_regs_tb_top;
	import pdecs_pkg::*;
	logic mclk_in = 1'b0;
	logic srst_in = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic aux = 1'b0;
	logic iss = 1'b0;
	logic dn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wd = 32'h0000_0000;
	logic [3:0] ev = 4'h0;
	logic [31:0] rdat, v;
	logic rv, mv, mc, mn, mf;
	logic [7:0] nc, nn, nfat;
	pdecs_msg_t mt;
	int miscompares = 0;
	int checks = 0;

	pdecs_regs u_pdecs_regs (.mclk_in(mclk_in), .srst_in(srst_in),
		.cfg_wr_in(wr), .cfg_rd_in(rd), .cfg_addr_in(addr),
		.cfg_wdata_in(wd), .cfg_rdata_out(rdat), .cfg_rvalid_out(rv),
		.corr_err_in(ev[0]), .nonfatal_err_in(ev[1]),
		.fatal_err_in(ev[2]), .unsupp_req_in(ev[3]),
		.np_issue_in(iss), .np_done_in(dn),
		.aux_power_present_in(aux), .msg_valid_out(mv),
		.msg_type_out(mt), .msg_cor_out(mc),
		.msg_nonfatal_out(mn), .msg_fatal_out(mf));
	pdecs_rc_model u_pdecs_rc_model (.mclk_in(mclk_in),
		.srst_in(srst_in), .msg_valid_in(mv), .msg_type_in(mt),
		.cor_cnt_out(nc), .nf_cnt_out(nn), .fat_cnt_out(nfat));

	initial begin
		forever #4 mclk_in = ~mclk_in;
	end

	task automatic stop_test();
		if (miscompares == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask

	// inputs move 1 ns after the edge to stay clear of sampling
	task automatic tick();
		@(posedge mclk_in);
		#1;
	endtask

	task automatic cfg_write(input logic [7:0] a, input logic [31:0] d);
		tick();
		wr = 1'b1;
		addr = a;
		wd = d;
		tick();
		wr = 1'b0;
	endtask

	task automatic cfg_read(input logic [7:0] a);
		tick();
		rd = 1'b1;
		addr = a;
		tick();
		rd = 1'b0;
		chk("rvalid", 32'h1, {31'h0, rv});
		v = rdat;
	endtask

	task automatic pulse(input int i, input logic [3:0] e);
		tick();
		ev[i] = 1'b1;
		tick();
		ev = 4'h0;
		chk("msg", {28'h0, e}, {28'h0, mv, mf, mn, mc});
	endtask

	task automatic t_reset();
		cfg_read(DEV_STAT_OFF);
		chk("status", 32'h0, {16'h0, v[15:0]});
		cfg_read(DEV_CTRL_OFF);
		chk("ctrl", 32'h0, {28'h0, v[3:0]});
		cfg_write(LINK_CAP_OFF, 32'hFFFF_FFFF);
		cfg_write(DEV_STAT_OFF, 32'h0000_FFC0);
		cfg_read(LINK_CAP_OFF);
		chk("linkcap", LINK_CAP_DEFAULT, v);
		cfg_read(DEV_STAT_OFF);
		chk("status", 32'h0, {16'h0, v[15:0]});
	endtask

	// correctable, nonfatal and fatal errors each first with reporting off, then on
	task automatic t_gate();
		for (int i = 0; i < 3; i++) begin
			pulse(i, 4'h0);
			cfg_write(DEV_STAT_OFF, 32'h0);
			cfg_read(DEV_STAT_OFF);
			chk("seen", 32'h1 << i, {16'h0, v[15:0]});
			cfg_write(DEV_STAT_OFF, 32'h1 << i);
			cfg_read(DEV_STAT_OFF);
			chk("cleared", 32'h0, {16'h0, v[15:0]});
			cfg_write(DEV_CTRL_OFF, 32'h1 << i);
			pulse(i, 4'h8 | (4'h1 << i));
			chk("type", 32'(i), 32'(mt));
			cfg_write(DEV_STAT_OFF, 32'h1 << i);
		end
		cfg_write(DEV_CTRL_OFF, 32'h0);
	endtask

	// new request in the same cycle as its clear must survive
	task automatic t_ur();
		pulse(3, 4'h0);
		cfg_write(DEV_CTRL_OFF, 32'h8);
		tick();
		ev[3] = 1'b1;
		wr = 1'b1;
		addr = DEV_STAT_OFF;
		wd = 32'h8;
		tick();
		ev = 4'h0;
		wr = 1'b0;
		chk("ur msg", 32'hA, {28'h0, mv, mf, mn, mc});
		cfg_read(DEV_STAT_OFF);
		chk("ur seen", 32'h8, {16'h0, v[15:0]});
		cfg_write(DEV_STAT_OFF, 32'h8);
		cfg_write(DEV_CTRL_OFF, 32'h0);
	endtask

	// mid-run reset must drop enables and sticky bits
	task automatic t_rst2();
		cfg_write(DEV_CTRL_OFF, 32'hF);
		pulse(2, 4'hC);
		srst_in = 1'b1;
		tick();
		tick();
		srst_in = 1'b0;
		cfg_read(DEV_CTRL_OFF);
		chk("ctrl rst", 32'h0, v);
	endtask

	// all three at once with a clear in the same cycle: sets win
	task automatic t_multi();
		cfg_write(DEV_CTRL_OFF, 32'h7);
		tick();
		ev = 4'h7;
		wr = 1'b1;
		addr = DEV_STAT_OFF;
		wd = 32'h7;
		tick();
		ev = 4'h0;
		wr = 1'b0;
		chk("multi msg", 32'hF, {28'h0, mv, mf, mn, mc});
		chk("multi type", 32'(PDECS_MSG_FATAL), 32'(mt));
		cfg_write(DEV_STAT_OFF, 32'h5);
		cfg_read(DEV_CTRL_OFF);
		chk("partial clr", 32'h0002_0007, v);
		cfg_write(DEV_STAT_OFF, 32'h2);
		cfg_write(DEV_CTRL_OFF, 32'h0);
	endtask

	task automatic t_nonposted_outstanding_aux();
		aux = 1'b1;
		iss = 1'b1;
		tick();
		tick();
		iss = 1'b0;
		dn = 1'b1;
		tick();
		dn = 1'b0;
		cfg_read(DEV_STAT_OFF);
		chk("nonposted_outstanding aux", 32'h30, {16'h0, v[15:0]});
		dn = 1'b1;
		aux = 1'b0;
		tick();
		dn = 1'b0;
		cfg_read(DEV_STAT_OFF);
		chk("nonposted_outstanding aux", 32'h0, {16'h0, v[15:0]});
	endtask

	initial begin
		repeat (6) @(posedge mclk_in);
		#1;
		srst_in = 1'b0;
		t_reset();
		t_rst2();
		t_gate();
		t_ur();
		t_multi();
		t_nonposted_outstanding_aux();
		chk("rc tally", 32'h0002_0201, {8'h0, nfat, nn, nc});
		stop_test();
	end
endmodule
